// file: shared/kms_pkg.sv
`default_nettype none
package kms_pkg;

  // ------------------------------------------------------------------
  // Clocking and timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int LP_OSC_HZ     = 128_000;
  // One matrix position per low-power oscillator period
  localparam int SCAN_TICK_CYC = CLK_HZ / LP_OSC_HZ;
  localparam int TICK_W        = 9;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SCAN_TICK_CYC - 1);
  localparam int GLITCH_NS     = 2000;
  localparam int GLITCH_CYC    = (GLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int GLITCH_W      = 7;
  localparam logic [GLITCH_W-1:0] GLITCH_LAST = GLITCH_W'(GLITCH_CYC - 1);

  // ------------------------------------------------------------------
  // Matrix and buffer geometry
  // ------------------------------------------------------------------
  localparam int NUM_ROWS  = 8;
  localparam int NUM_COLS  = 20;
  localparam int MAX_KEYS  = 160;
  localparam int KEY_W     = 8;
  localparam int BUF_DEPTH = 16;
  localparam int BUF_AW    = 4;
  localparam logic [4:0] COLS_MAX_V = 5'h14;
  localparam logic [3:0] ROWS_MAX_V = 4'h8;
  localparam logic [BUF_AW:0] BUF_FULL_V = 5'h10;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] KEY_OFF  = 8'h08;

  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_COLS_LSB  = 8;
  localparam int CTRL_ROWS_LSB  = 16;
  localparam int STAT_GHOST_BIT = 0;
  localparam int STAT_OVF_BIT   = 1;
  localparam int STAT_REQ_BIT   = 2;
  localparam int STAT_RUN_BIT   = 3;
  localparam int STAT_CNT_LSB   = 8;
  localparam int STAT_ST_LSB    = 16;
  localparam int KEY_VALID_BIT  = 8;

  localparam logic       CTRL_EN_RST   = 1'b0;
  localparam logic [4:0] CTRL_COLS_RST = 5'h14;
  localparam logic [3:0] CTRL_ROWS_RST = 4'h8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    KMS_IDLE = 4'h1,
    KMS_WAIT = 4'h2,
    KMS_SCAN = 4'h4,
    KMS_END  = 4'h8
  } kms_state_t;

endpackage
`default_nettype wire

// file: src/kms_row_filter.sv
`timescale 1ns/1ns
`default_nettype none
module kms_row_filter import kms_pkg::*; (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [NUM_ROWS-1:0] row_pin,
  output var  logic [NUM_ROWS-1:0] row_flt
);

  logic [NUM_ROWS-1:0] s1_r;
  logic [NUM_ROWS-1:0] s2_r;
  logic [NUM_ROWS-1:0] s3_r;
  logic [NUM_ROWS-1:0] stable_r;

  // ------------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r     <= '0;
      s2_r     <= '0;
      s3_r     <= '0;
      stable_r <= '0;
    end else begin
      s1_r <= row_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < NUM_ROWS; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          stable_r[i] <= s3_r[i];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Per-row glitch filter
  // ------------------------------------------------------------------
  // A level must hold for the whole filter time before it is accepted
  for (genvar g = 0; g < NUM_ROWS; g++) begin : g_row
    logic [GLITCH_W-1:0] cnt_r;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_r      <= '0;
        row_flt[g] <= 1'b0;
      end else if (stable_r[g] == row_flt[g]) begin
        cnt_r <= '0;
      end else if (cnt_r == GLITCH_LAST) begin
        cnt_r      <= '0;
        row_flt[g] <= stable_r[g];
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// file: src/kms_scanner.sv
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module kms_scanner import kms_pkg::*; (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [NUM_ROWS-1:0] row_in,
  output logic [NUM_COLS-1:0]      col_out,
  input  wire logic                osc_run_in,
  input  wire logic                periph_req_in,
  output logic                     lp_clk_req,
  output logic                     osc_start
);

  // ------------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------------
  function automatic logic [4:0] lim_cols(input logic [4:0] v);
    if (v == 5'h00) begin
      return 5'h01;
    end else if (v > COLS_MAX_V) begin
      return COLS_MAX_V;
    end
    return v;
  endfunction

  function automatic logic [3:0] lim_rows(input logic [3:0] v);
    if (v == 4'h0) begin
      return 4'h1;
    end else if (v > ROWS_MAX_V) begin
      return ROWS_MAX_V;
    end
    return v;
  endfunction

  function automatic logic two_plus(input logic [NUM_ROWS-1:0] v);
    return (v & (v - 1'b1)) != '0;
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  kms_state_t            state_r;
  kms_state_t            state_nxt;
  logic [NUM_ROWS-1:0]   row_flt;
  logic [NUM_ROWS-1:0]   row_prev_r;
  logic                  osc_s1_r;
  logic                  osc_s2_r;
  logic                  osc_s3_r;
  logic                  osc_run_r;
  logic                  en_r;
  logic [4:0]            cols_r;
  logic [3:0]            rows_r;
  logic [4:0]            cols_lim;
  logic [3:0]            rows_lim;
  logic [TICK_W-1:0]     tick_cnt_r;
  logic                  tick;
  logic [2:0]            row_cnt_r;
  logic [4:0]            col_cnt_r;
  logic [KEY_W-1:0]      key_idx_r;
  logic [NUM_ROWS-1:0]   row_hit_r;
  logic [NUM_ROWS-1:0]   col_vec_r;
  logic [NUM_ROWS-1:0]   col_vec_now;
  logic                  last_row;
  logic                  last_col;
  logic                  hit;
  logic                  ghost_hit;
  logic                  any_key_r;
  logic [MAX_KEYS-1:0]   prev_key_r;
  logic                  push_req;
  logic                  push;
  logic                  pop;
  logic [KEY_W-1:0]      buf_mem_r [BUF_DEPTH];
  logic [BUF_AW-1:0]     wp_r;
  logic [BUF_AW-1:0]     rp_r;
  logic [BUF_AW:0]       cnt_r;
  logic                  ghost_r;
  logic                  ovf_r;
  logic                  aw_held_r;
  logic                  w_held_r;
  logic [ADDR_W-1:0]     aw_addr_r;
  logic [31:0]           w_data_r;
  logic [3:0]            w_strb_r;
  logic                  do_wr;
  logic                  clr_ghost;
  logic                  clr_ovf;
  logic                  ar_hs;
  logic [31:0]           rd_word;
  logic                  rd_ok;

  kms_row_filter u_flt (
    .clk     (clk),
    .rst_n   (rst_n),
    .row_pin (row_in),
    .row_flt (row_flt)
  );

  // ------------------------------------------------------------------
  // Oscillator running indication
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_r  <= 1'b0;
      osc_s2_r  <= 1'b0;
      osc_s3_r  <= 1'b0;
      osc_run_r <= 1'b0;
    end else begin
      osc_s1_r <= osc_run_in;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      if (osc_s2_r == osc_s3_r) begin
        osc_run_r <= osc_s3_r;
      end
    end
  end

  // Shared oscillator is a wired-or of all peripheral requests
  assign osc_start = lp_clk_req | periph_req_in;

  // ------------------------------------------------------------------
  // Scan state machine
  // ------------------------------------------------------------------
  assign cols_lim    = lim_cols(cols_r);
  assign rows_lim    = lim_rows(rows_r);
  assign tick        = (state_r == KMS_SCAN) && (tick_cnt_r == TICK_LAST);
  assign last_row    = ({1'b0, row_cnt_r} == rows_lim - 4'h1);
  assign last_col    = (col_cnt_r == cols_lim - 5'h01);
  assign hit         = row_flt[row_cnt_r];
  assign col_vec_now = col_vec_r | (hit ? (NUM_ROWS'(1) << row_cnt_r) : '0);
  assign ghost_hit   = tick && hit && row_hit_r[row_cnt_r];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      KMS_IDLE: begin
        if (row_flt != row_prev_r) begin
          state_nxt = KMS_WAIT;
        end
      end
      KMS_WAIT: begin
        // Another peripheral may already have the oscillator running
        if (osc_run_r) begin
          state_nxt = KMS_SCAN;
        end
      end
      KMS_SCAN: begin
        if (tick && last_row && last_col) begin
          state_nxt = KMS_END;
        end
      end
      KMS_END: begin
        state_nxt = any_key_r ? KMS_SCAN : KMS_IDLE;
      end
      default: state_nxt = KMS_IDLE;
    endcase
    if (!en_r) begin
      state_nxt = KMS_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= KMS_IDLE;
      lp_clk_req <= 1'b0;
      row_prev_r <= '0;
    end else begin
      state_r    <= state_nxt;
      lp_clk_req <= en_r && (state_nxt != KMS_IDLE);
      row_prev_r <= row_flt;
    end
  end

  // Active column driven high, the rest low; all high outside a pass
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      col_out <= '1;
    end else if (state_r == KMS_SCAN) begin
      col_out <= NUM_COLS'(1) << col_cnt_r;
    end else begin
      col_out <= '1;
    end
  end

  // ------------------------------------------------------------------
  // Counters and ghost tracking
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
      row_cnt_r  <= '0;
      col_cnt_r  <= '0;
      key_idx_r  <= '0;
      row_hit_r  <= '0;
      col_vec_r  <= '0;
    end else if (state_r != KMS_SCAN) begin
      tick_cnt_r <= '0;
      row_cnt_r  <= '0;
      col_cnt_r  <= '0;
      key_idx_r  <= '0;
      row_hit_r  <= '0;
      col_vec_r  <= '0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
      if (tick) begin
        key_idx_r <= key_idx_r + 8'h01;
        if (last_row) begin
          row_cnt_r <= '0;
          col_cnt_r <= col_cnt_r + 5'h01;
          col_vec_r <= '0;
          if (two_plus(col_vec_now)) begin
            row_hit_r <= row_hit_r | col_vec_now;
          end
        end else begin
          row_cnt_r <= row_cnt_r + 3'h1;
          col_vec_r <= col_vec_now;
        end
      end
    end
  end

  // Key presence per pass and per position; only new presses are stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      any_key_r  <= 1'b0;
      prev_key_r <= '0;
    end else begin
      if (state_r == KMS_SCAN) begin
        if (tick && hit) begin
          any_key_r <= 1'b1;
        end
      end else begin
        any_key_r <= 1'b0;
      end
      if (tick) begin
        prev_key_r[key_idx_r] <= hit;
      end
    end
  end

  // A ghosted position is locked out of the buffer; other new presses go in while it has room
  assign push_req = tick && hit && !prev_key_r[key_idx_r] && !ghost_hit;
  assign push     = push_req && (cnt_r != BUF_FULL_V);

  // ------------------------------------------------------------------
  // Key code buffer
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (push ? 5'h01 : 5'h00) - (pop ? 5'h01 : 5'h00);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      buf_mem_r[wp_r] <= key_idx_r;
    end
  end

  // ------------------------------------------------------------------
  // Sticky status flags
  // ------------------------------------------------------------------
  // Hardware set wins over a same-cycle software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ghost_r <= 1'b0;
      ovf_r   <= 1'b0;
    end else begin
      ghost_r <= (ghost_r && !clr_ghost) || ghost_hit;
      ovf_r   <= (ovf_r && !clr_ovf) || (push_req && !push);
    end
  end

  // ------------------------------------------------------------------
  // Register bus, write channels
  // ------------------------------------------------------------------
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign do_wr         = aw_held_r && w_held_r;
  assign clr_ghost     = do_wr && (aw_addr_r == STAT_OFF) && w_strb_r[0]
                         && w_data_r[STAT_GHOST_BIT];
  assign clr_ovf       = do_wr && (aw_addr_r == STAT_OFF) && w_strb_r[0]
                         && w_data_r[STAT_OVF_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      aw_addr_r    <= '0;
      w_data_r     <= '0;
      w_strb_r     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r == CTRL_OFF || aw_addr_r == STAT_OFF
                         || aw_addr_r == KEY_OFF) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r   <= CTRL_EN_RST;
      cols_r <= CTRL_COLS_RST;
      rows_r <= CTRL_ROWS_RST;
    end else if (do_wr && aw_addr_r == CTRL_OFF) begin
      if (w_strb_r[0]) begin
        en_r <= w_data_r[CTRL_EN_BIT];
      end
      if (w_strb_r[1]) begin
        cols_r <= w_data_r[CTRL_COLS_LSB +: 5];
      end
      if (w_strb_r[2]) begin
        rows_r <= w_data_r[CTRL_ROWS_LSB +: 4];
      end
    end
  end

  // ------------------------------------------------------------------
  // Register bus, read channels
  // ------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign pop           = ar_hs && (s_axi_araddr == KEY_OFF) && (cnt_r != '0);

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      CTRL_OFF: begin
        rd_word[CTRL_EN_BIT]          = en_r;
        rd_word[CTRL_COLS_LSB +: 5]   = cols_r;
        rd_word[CTRL_ROWS_LSB +: 4]   = rows_r;
      end
      STAT_OFF: begin
        rd_word[STAT_GHOST_BIT]       = ghost_r;
        rd_word[STAT_OVF_BIT]         = ovf_r;
        rd_word[STAT_REQ_BIT]         = lp_clk_req;
        rd_word[STAT_RUN_BIT]         = osc_run_r;
        rd_word[STAT_CNT_LSB +: 5]    = cnt_r;
        rd_word[STAT_ST_LSB +: 4]     = state_r;
      end
      KEY_OFF: begin
        rd_word[KEY_VALID_BIT]        = (cnt_r != '0);
        rd_word[KEY_W-1:0]            = (cnt_r != '0) ? buf_mem_r[rp_r] : '0;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: dv/kms_matrix_model.sv
`timescale 1ns/1ns
`default_nettype none
module kms_matrix_model import kms_pkg::*; (
  input  wire logic                               clk,
  input  wire logic [NUM_COLS-1:0]                col_out,
  input  wire logic [NUM_COLS-1:0][NUM_ROWS-1:0]  keys,
  input  wire logic                               osc_start,
  output logic      [NUM_ROWS-1:0]                row_in,
  output logic                                    osc_run_in
);
  logic [3:0] osc_sh_r = 4'h0;
  // Oscillator comes up a few cycles after any request
  always @(posedge clk) osc_sh_r <= {osc_sh_r[2:0], osc_start};
  assign osc_run_in = osc_sh_r[3];
  // Rows have pull-downs: a row is high only through a pressed key on a driven column
  always_comb begin
    row_in = '0;
    for (int c = 0; c < NUM_COLS; c++) row_in |= keys[c] & {NUM_ROWS{col_out[c]}};
  end
endmodule
`default_nettype wire

// file: dv/kms_scanner_sva.sv
`timescale 1ns/1ns
`default_nettype none
module kms_scanner_sva import kms_pkg::*; (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [NUM_COLS-1:0] col_out,
  input wire logic                periph_req_in,
  input wire logic                lp_clk_req,
  input wire logic                osc_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [NUM_COLS-1:0] col_q_r;
  logic [15:0]         hold_r;
  // Counts how long the previous column drive has stood
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      col_q_r <= '1;
      hold_r  <= 16'h0;
    end else begin
      col_q_r <= col_out;
      hold_r  <= (col_out != col_q_r) ? 16'h0 : hold_r + 16'h1;
    end
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Address and data are latched first; the response follows one cycle after that
  property p_wr_resp; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
  property p_rd_resp; s_rd_taken |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response missing");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_block: assert property (p_w_block) else $error("write accepted during response");
  property p_osc; osc_start == (lp_clk_req || periph_req_in); endproperty
  a_osc: assert property (p_osc) else $error("oscillator start wrong");
  property p_onehot; col_out != '1 |-> $onehot(col_out); endproperty
  a_onehot: assert property (p_onehot) else $error("column drive not one-hot");
  property p_scan_req; col_out != '1 |-> lp_clk_req || $past(lp_clk_req); endproperty
  a_scan_req: assert property (p_scan_req) else $error("scanning without request");
  property p_req_rise; $rose(lp_clk_req) |-> col_out == '1; endproperty
  a_req_rise: assert property (p_req_rise) else $error("request raised outside idle");
  property p_dwell;
    (col_out != col_q_r) && (col_q_r != '1) && (col_out != '1) |-> hold_r >= 16'(TICK_LAST);
  endproperty
  a_dwell: assert property (p_dwell) else $error("column dwell too short");
endmodule
bind kms_scanner kms_scanner_sva u_sva (.*);
`default_nettype wire

// file: dv/key_matrix_scanner_test.sv
`timescale 1ns/1ns
`default_nettype none
module key_matrix_scanner_test import kms_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, d;
  logic periph_req_in = 1'b0;
  logic [NUM_COLS-1:0][NUM_ROWS-1:0] keys = '0;
  logic awready, wready, bvalid, arready, rvalid, lp_clk_req, osc_start, osc_run_in;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata;
  logic [NUM_ROWS-1:0] row_in;
  logic [NUM_COLS-1:0] col_out;
  int miscompares = 0, n_compared = 0, cyc = 0, rows, cols, c, r;
  logic [31:0] seed = 32'h20541d46;
  always #10 clk = ~clk;
  kms_scanner uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .row_in(row_in), .col_out(col_out), .osc_run_in(osc_run_in),
    .periph_req_in(periph_req_in), .lp_clk_req(lp_clk_req), .osc_start(osc_start));
  kms_matrix_model u_mx (.clk(clk), .col_out(col_out), .keys(keys), .osc_start(osc_start),
    .row_in(row_in), .osc_run_in(osc_run_in));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] ctrl(int rw, int cl);
    return (32'(rw) << 16) | (32'(cl) << 8) | 32'h1;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      final_report();
    end
  end
  // Handshakes are judged at the falling edge and acted on at the next rising edge
  // Ready is raised only once the response is seen, so the slave must hold it a cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ha, hw, hb, hv;
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1;
    do begin
      @(negedge clk);
      ha = awvalid && awready; hw = wvalid && wready; hb = bvalid && bready; rsp = bresp;
      hv = bvalid;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hv && !hb) bready <= 1'b1;
    end while (!hb);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ha, hr, hv;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1;
    do begin
      @(negedge clk);
      ha = arvalid && arready; hr = rvalid && rready; d = rdata; rsp = rresp;
      hv = rvalid;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
      if (hv && !hr) rready <= 1'b1;
    end while (!hr);
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    rd(a);
    chk(d, v);
    chk(32'(rsp), 32'(e));
  endtask
  task automatic wait_req(input logic v);
    for (int i = 0; i < 20000 && lp_clk_req !== v; i++) @(posedge clk);
    chk(32'(lp_clk_req), 32'(v));
  endtask
  // Keys are held for two whole passes, then released until the scanner idles
  task automatic hold_keys(input int pass);
    wait_req(1'b1);
    repeat (2 * pass + 200) @(posedge clk);
    keys <= '0;
    wait_req(1'b0);
    chk(32'(col_out), 32'(20'hfffff));
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk(CTRL_OFF, 32'h00081400, RESP_OKAY);
    rchk(STAT_OFF, 32'h00010000, RESP_OKAY);
    rchk(8'h0c, 32'h0, RESP_SLVERR);
    wr(8'h0c, 32'hffffffff);
    chk(32'(rsp), 32'(RESP_SLVERR));
    @(posedge clk) keys[0][0] <= 1'b1;
    repeat (600) @(posedge clk);
    chk(32'(lp_clk_req), 32'h0);
    periph_req_in <= 1'b1;
    keys <= '0;
    repeat (300) @(posedge clk);
    periph_req_in <= 1'b0;
    $display("test reset and disable done");
    for (int k = 0; k < 2; k++) begin
      rows = 1 + xs() % 4;
      cols = 1 + xs() % 2;
      c = xs() % cols;
      r = xs() % rows;
      wr(CTRL_OFF, ctrl(rows, cols));
      @(posedge clk) keys[c][r] <= 1'b1;
      hold_keys(rows * cols * 390);
      rchk(KEY_OFF, 32'h100 | 32'(c * rows + r), RESP_OKAY);
      rchk(KEY_OFF, 32'h0, RESP_OKAY);
    end
    $display("test random key done");
    wr(CTRL_OFF, ctrl(2, 2));
    @(posedge clk) {keys[0][0], keys[0][1], keys[1][0]} <= 3'h7;
    hold_keys(1560);
    rd(STAT_OFF);
    chk(d & 32'h1, 32'h1);
    rchk(KEY_OFF, 32'h100, RESP_OKAY);
    rchk(KEY_OFF, 32'h101, RESP_OKAY);
    rchk(KEY_OFF, 32'h0, RESP_OKAY);
    wr(STAT_OFF, 32'h1);
    rd(STAT_OFF);
    chk(d & 32'h1, 32'h0);
    $display("test ghost done");
    wr(CTRL_OFF, ctrl(1, 1));
    // A pulse shorter than the row filter time must not wake the scanner
    keys[0][0] <= 1'b1;
    repeat (50) @(posedge clk);
    keys <= '0;
    repeat (200) @(posedge clk);
    chk(32'(lp_clk_req), 32'h0);
    repeat (17) begin
      @(posedge clk) keys[0][0] <= 1'b1;
      hold_keys(390);
    end
    rd(STAT_OFF);
    chk(d & 32'h1f02, 32'h1002);
    repeat (16) rchk(KEY_OFF, 32'h100, RESP_OKAY);
    rchk(KEY_OFF, 32'h0, RESP_OKAY);
    $display("test overflow done");
    final_report();
  end
endmodule
`default_nettype wire
